// ===== valve_alert_defines.svh
// Constants for the valve alert and shutdown monitor: register offsets,
// field positions, reset values and timing counts.
// Assumes a 20 MHz core clock and a 32-bit AXI4-Lite register port.
`ifndef VALVE_ALERT_DEFINES_SVH
`define VALVE_ALERT_DEFINES_SVH

`define CLK_HZ              20000000
`define TICK_US             1000
`define TICK_CYCLES         ((`CLK_HZ / 1000000) * `TICK_US)

`define REG_CTRL            8'h00
`define REG_ENABLE          8'h04
`define REG_CATEGORY        8'h08
`define REG_MISMATCH_THR    8'h0C
`define REG_MISMATCH_TIME   8'h10
`define REG_OUT_TIMEOUT     8'h14
`define REG_ACK_TIMEOUT     8'h18
`define REG_ALERT_KEY       8'h1C
`define REG_STATUS          8'h20
`define REG_MASK            8'h24
`define REG_ACTIVE          8'h28
`define REG_MODE            8'h2C

`define CTRL_ARM            0
`define CTRL_AUTO_RESUME    1
`define CTRL_ZP_OPEN        2
`define CTRL_TARGET_WR      3

`define NUM_ALERTS          7
`define AL_MISMATCH         0
`define AL_SATURATION       1
`define AL_PROG_MEM         2
`define AL_STATIC_MEM       3
`define AL_MAIN_CPU         4
`define AL_IO_CPU           5
`define AL_OUT_TIMEOUT      6
`define AL_DEFAULTS         7
`define SHUTDOWN_CAPABLE    8'h6D

`define IRQ_ALERT           0
`define IRQ_RETRY           1
`define IRQ_SHUTDOWN        2

`define DRIVE_LO_PCT        8'h0A
`define DRIVE_HI_PCT        8'h5A
`define TRAVEL_LO_PCT       8'h03
`define TRAVEL_HI_PCT       8'h61

`define RST_ENABLE          8'hFF
`define RST_THR             8'h05
`define RST_TIME            16'h0005
`define RST_ACK_TIMEOUT     16'h0064
`define RST_OUT_TIMEOUT     16'h03E8
`endif

// ===== valve_alert_pkg.sv
// Types for the valve alert monitor.
// Assumes valve_alert_defines.svh is compiled alongside.
package valve_alert_pkg;
    typedef enum logic [1:0] {
        MODE_OOS,
        MODE_MAN,
        MODE_AUTO
    } xd_mode_e;

    typedef enum {
        NOTE_IDLE,
        NOTE_SEND,
        NOTE_WAIT
    } note_state_e;

    typedef struct packed {
        logic [7:0] key;
        logic [7:0] alerts;
        logic [7:0] category;
    } notice_s;
endpackage : valve_alert_pkg

// ===== valve_alert_monitor.sv
// Alert detection, self-test shutdown and notification retry logic.
// Assumes inputs from the processor side are synchronous to CORE_CLK;
// percent inputs are 0..100 in 8 bits.
//
// Functional notes
// R1 - Plant alert sends a notice, then waits for acknowledgment regardless.
// R2 - Host must acknowledge; on time-out the same notice is resent.
// R3 - Each alert reported as failed, maintenance or advisory, per user; notices carry only category_ff[7:0] of the 16-bit category register.
// R4 - Mismatch alert when drive error exceeds threshold longer than set time.
// R5 - Each alert active only while its own enable bit is set.
// R6 - Armed shutdown forces out of service and zero-power drive.
// R7 - Auto resume returns to target mode once the cause clears.
// R8 - Without auto resume stay out of service until reset or mode write.
// R9 - Stay out of service while cause persists unless disarmed.
// R10 - Closed zero-power: saturation on low drive/high travel or reverse.
// R11 - Open zero-power: saturation on low drive/low travel or reverse.
// R12 - Program memory alert on pending flash or store failure; can shut down.
// R13 - Static memory alert on ferro store failure; can shut down.
// R14 - Main and I/O processor alerts; only I/O one can shut down.
// R15 - Output timeout alert when setpoint not updated in interval.
// R16 - Defaults alert after default restart until left out of service; the code clears it on any mode write to a non-OOS target, even while shut down.
// R17 - User plant key held and attached to every alert notice.
// R18 - Persistence timers tick from clock, clear on drop and reset.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`include "valve_alert_defines.svh"

module valve_alert_monitor (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic [7:0]  DRIVE_CMD,
    input  wire logic [7:0]  DRIVE_MEAS,
    input  wire logic [7:0]  TRAVEL,
    input  wire logic        PROG_MEM_FAIL,
    input  wire logic        STATIC_MEM_FAIL,
    input  wire logic        MAIN_CPU_FAIL,
    input  wire logic        IO_CPU_FAIL,
    input  wire logic        SETPOINT_UPDATE,
    input  wire logic        DEFAULTS_RESTART,
    input  wire logic        NOTE_ACK,
    output logic             NOTE_VALID,
    output valve_alert_pkg::notice_s NOTE_DATA,
    output logic             SHUTDOWN,
    output logic [1:0]       ACTUAL_MODE,
    output logic             IRQ,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    localparam int TICK = `TICK_CYCLES;

    // Control registers
    logic [3:0]  ctrl_ff;
    logic [7:0]  enable_ff;
    logic [15:0] category_ff;
    logic [7:0]  thr_ff;
    logic [15:0] mis_time_ff;
    logic [15:0] out_to_ff;
    logic [15:0] ack_to_ff;
    logic [7:0]  key_ff;
    logic [2:0]  status_ff;
    logic [2:0]  mask_ff;
    logic [1:0]  target_ff;

    // Bus slave state
    logic [7:0]  awaddr_ff;
    logic        aw_held_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        w_held_ff;

    // Alert state
    logic [15:0] tick_cnt_ff;
    logic [15:0] mis_cnt_ff;
    logic [15:0] out_cnt_ff;
    logic        defaults_ff;
    logic        shut_ff;
    logic [7:0]  alerts_ff;
    logic [7:0]  prev_alerts_ff;
    logic [15:0] ack_cnt_ff;
    valve_alert_pkg::note_state_e note_st_ff;

    function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                            input logic [7:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction : abs_diff

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    // Write path: address and data taken in either order
    wire        wr_go  = aw_held_ff && w_held_ff && !S_AXI_BVALID;
    wire [31:0] wd     = wdata_ff;
    wire [3:0]  be     = wstrb_ff;
    wire        wr_ctl = wr_go && awaddr_ff == `REG_CTRL;
    wire        wr_mode_cmd = wr_ctl && be[0] && wd[`CTRL_TARGET_WR];
    wire [1:0]  new_target = wd[5:4];
    wire        tick   = tick_cnt_ff == 16'(TICK - 1);

    assign S_AXI_AWREADY = !aw_held_ff;
    assign S_AXI_WREADY  = !w_held_ff;
    assign S_AXI_BRESP   = 2'h0;
    assign S_AXI_RRESP   = 2'h0;
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    // Alert conditions
    wire mis_raw = abs_diff(DRIVE_MEAS, DRIVE_CMD) > thr_ff;
    wire mis_hit = mis_raw && mis_cnt_ff > mis_time_ff; // R4
    wire lo_drv  = DRIVE_CMD < `DRIVE_LO_PCT;
    wire hi_drv  = DRIVE_CMD > `DRIVE_HI_PCT;
    wire tv_lo   = TRAVEL < `TRAVEL_HI_PCT;
    wire tv_hi   = TRAVEL > `TRAVEL_LO_PCT;
    wire sat_cl  = (lo_drv && tv_hi) || (hi_drv && tv_lo); // R10
    wire sat_op  = (lo_drv && tv_lo) || (hi_drv && tv_hi); // R11
    wire sat_hit = ctrl_ff[`CTRL_ZP_OPEN] ? sat_op : sat_cl;
    wire out_hit = out_cnt_ff >= out_to_ff; // R15
    wire [7:0] raw_alerts = {defaults_ff, out_hit, IO_CPU_FAIL,
                             MAIN_CPU_FAIL, STATIC_MEM_FAIL,
                             PROG_MEM_FAIL, sat_hit, mis_hit}; // R12 R13 R14
    wire [7:0] nxt_alerts = raw_alerts & enable_ff; // R5
    wire       cause = |(nxt_alerts & `SHUTDOWN_CAPABLE); // R14
    wire       armed = ctrl_ff[`CTRL_ARM];
    wire       new_alert = |(alerts_ff & ~prev_alerts_ff);
    wire       ack_exp = ack_cnt_ff >= ack_to_ff;
    wire [2:0] events = {armed && cause && !shut_ff,
                         note_st_ff == valve_alert_pkg::NOTE_WAIT && ack_exp,
                         new_alert};

    // Shutdown release: auto resume on clear, manual on mode write
    wire release_ok = !armed || (!cause &&
        (ctrl_ff[`CTRL_AUTO_RESUME] ||
         (wr_mode_cmd && new_target != 2'(valve_alert_pkg::MODE_OOS))));
    // R7 R8 R9

    assign SHUTDOWN    = shut_ff; // R6
    assign ACTUAL_MODE = shut_ff ? 2'(valve_alert_pkg::MODE_OOS)
                                 : target_ff; // R6
    assign IRQ         = |(status_ff & mask_ff);

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0;
            wstrb_ff   <= 4'h0;
            S_AXI_BVALID <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && !aw_held_ff) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && !w_held_ff) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= S_AXI_WDATA;
                wstrb_ff  <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
            end
        end
    end

    // Read path; unmapped addresses answer zero with OKAY
    logic [31:0] rd_mux;
    always_comb begin
        case (S_AXI_ARADDR)
            `REG_CTRL:          rd_mux = {28'h0, ctrl_ff};
            `REG_ENABLE:        rd_mux = {24'h0, enable_ff};
            `REG_CATEGORY:      rd_mux = {16'h0, category_ff};
            `REG_MISMATCH_THR:  rd_mux = {24'h0, thr_ff};
            `REG_MISMATCH_TIME: rd_mux = {16'h0, mis_time_ff};
            `REG_OUT_TIMEOUT:   rd_mux = {16'h0, out_to_ff};
            `REG_ACK_TIMEOUT:   rd_mux = {16'h0, ack_to_ff};
            `REG_ALERT_KEY:     rd_mux = {24'h0, key_ff};
            `REG_STATUS:        rd_mux = {29'h0, status_ff};
            `REG_MASK:          rd_mux = {29'h0, mask_ff};
            `REG_ACTIVE:        rd_mux = {24'h0, alerts_ff};
            `REG_MODE:          rd_mux = {29'h0, shut_ff, ACTUAL_MODE};
            default:            rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0;
        end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_mux;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Register writes
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            ctrl_ff     <= 4'h0;
            enable_ff   <= `RST_ENABLE;
            category_ff <= 16'h0;
            thr_ff      <= `RST_THR;
            mis_time_ff <= `RST_TIME;
            out_to_ff   <= `RST_OUT_TIMEOUT;
            ack_to_ff   <= `RST_ACK_TIMEOUT;
            key_ff      <= 8'h00;
            mask_ff     <= 3'h0;
            target_ff   <= 2'(valve_alert_pkg::MODE_AUTO);
        end else if (wr_go) begin
            case (awaddr_ff)
                `REG_CTRL: begin
                    ctrl_ff <= 4'(merge({28'h0, ctrl_ff}, wd, be));
                    if (wr_mode_cmd) begin
                        target_ff <= new_target;
                    end
                end
                `REG_ENABLE:        enable_ff   <= 8'(merge(32'h0, wd, be));
                `REG_CATEGORY:      category_ff <= 16'(merge(32'h0, wd, be));
                `REG_MISMATCH_THR:  thr_ff      <= 8'(merge(32'h0, wd, be));
                `REG_MISMATCH_TIME: mis_time_ff <= 16'(merge(32'h0, wd, be));
                `REG_OUT_TIMEOUT:   out_to_ff   <= 16'(merge(32'h0, wd, be));
                `REG_ACK_TIMEOUT:   ack_to_ff   <= 16'(merge(32'h0, wd, be));
                `REG_ALERT_KEY:     key_ff      <= wd[7:0]; // R17
                `REG_MASK:          mask_ff     <= wd[2:0];
                default: ;
            endcase
        end
    end

    // Sticky status; a set wins over a same-cycle clear
    wire [2:0] clr = (wr_go && awaddr_ff == `REG_STATUS && be[0])
                     ? wd[2:0] : 3'h0;
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            status_ff <= 3'h0;
        end else begin
            status_ff <= (status_ff & ~clr) | events;
        end
    end

    // Persistence timers
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            tick_cnt_ff <= 16'h0; // R18
            mis_cnt_ff  <= 16'h0;
            out_cnt_ff  <= 16'h0;
        end else begin
            tick_cnt_ff <= tick ? 16'h0 : tick_cnt_ff + 16'h1;
            if (!mis_raw) begin
                mis_cnt_ff <= 16'h0; // R18
            end else if (tick && mis_cnt_ff != 16'hFFFF) begin
                mis_cnt_ff <= mis_cnt_ff + 16'h1; // R4
            end
            if (SETPOINT_UPDATE) begin
                out_cnt_ff <= 16'h0;
            end else if (tick && !out_hit) begin
                out_cnt_ff <= out_cnt_ff + 16'h1; // R15
            end
        end
    end

    // Alerts, defaults latch and shutdown
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            defaults_ff    <= 1'b0;
            alerts_ff      <= 8'h00;
            prev_alerts_ff <= 8'h00;
            shut_ff        <= 1'b0;
        end else begin
            if (DEFAULTS_RESTART) begin
                defaults_ff <= 1'b1; // R16
            end else if (wr_mode_cmd &&
                         new_target != 2'(valve_alert_pkg::MODE_OOS)) begin
                defaults_ff <= 1'b0; // R16
            end
            alerts_ff      <= nxt_alerts;
            prev_alerts_ff <= alerts_ff;
            if (armed && cause) begin
                shut_ff <= 1'b1; // R6
            end else if (shut_ff && release_ok) begin
                shut_ff <= 1'b0; // R7
            end
        end
    end

    // Notification with retry until acknowledged
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            note_st_ff <= valve_alert_pkg::NOTE_IDLE;
            ack_cnt_ff <= 16'h0;
            NOTE_VALID <= 1'b0;
            NOTE_DATA  <= '0;
        end else begin
            case (note_st_ff)
                valve_alert_pkg::NOTE_IDLE: begin
                    if (new_alert) begin
                        NOTE_DATA.key      <= key_ff; // R17
                        NOTE_DATA.alerts   <= alerts_ff;
                        NOTE_DATA.category <= category_ff[7:0]; // R3
                        NOTE_VALID         <= 1'b1; // R1
                        note_st_ff <= valve_alert_pkg::NOTE_SEND;
                    end
                end
                valve_alert_pkg::NOTE_SEND: begin
                    NOTE_VALID <= 1'b0;
                    ack_cnt_ff <= 16'h0;
                    note_st_ff <= valve_alert_pkg::NOTE_WAIT;
                end
                valve_alert_pkg::NOTE_WAIT: begin
                    if (NOTE_ACK) begin
                        note_st_ff <= valve_alert_pkg::NOTE_IDLE; // R2
                    end else if (ack_exp) begin
                        NOTE_VALID <= 1'b1; // R2
                        note_st_ff <= valve_alert_pkg::NOTE_SEND;
                    end else if (tick) begin
                        ack_cnt_ff <= ack_cnt_ff + 16'h1;
                    end
                end
                default: note_st_ff <= valve_alert_pkg::NOTE_IDLE;
            endcase
        end
    end

    // Checks
    sequence cause_seen;
        armed && cause;
    endsequence
    shutdown_entry_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) cause_seen |=> SHUTDOWN && ACTUAL_MODE == 2'h0)
        else $error("shutdown not entered"); // R6
    hold_oos_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) SHUTDOWN && armed && cause |=> SHUTDOWN)
        else $error("shutdown released early"); // R9
    auto_resume_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) SHUTDOWN && !cause && ctrl_ff[`CTRL_AUTO_RESUME]
        |=> !SHUTDOWN)
        else $error("auto resume failed"); // R7
    manual_hold_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) SHUTDOWN && armed && !ctrl_ff[`CTRL_AUTO_RESUME]
        && !wr_go |=> SHUTDOWN)
        else $error("manual hold lost"); // R8
    enable_gate_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) (alerts_ff & ~$past(enable_ff)) == 8'h00)
        else $error("disabled alert active"); // R5
    mismatch_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) !mis_raw |=> !alerts_ff[`AL_MISMATCH])
        else $error("mismatch without cause"); // R4
    sat_closed_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) !ctrl_ff[`CTRL_ZP_OPEN] && enable_ff[1] && lo_drv
        && tv_hi |=> alerts_ff[`AL_SATURATION])
        else $error("saturation missed"); // R10
    sat_open_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) ctrl_ff[`CTRL_ZP_OPEN] && enable_ff[1] && hi_drv
        && tv_hi |=> alerts_ff[`AL_SATURATION])
        else $error("open saturation missed"); // R11
    retry_a: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) note_st_ff == valve_alert_pkg::NOTE_WAIT && !NOTE_ACK
        && ack_exp |=> NOTE_VALID ##1 !NOTE_VALID)
        else $error("no retransmit"); // R2
endmodule : valve_alert_monitor

// ===== valve_host_model.sv
// Host side model: takes alert notices and acknowledges them.
// Assumes one-cycle notice pulses on the core clock.
module valve_host_model (
    input  wire logic                     clk,
    input  wire logic                     note_valid,
    input  wire valve_alert_pkg::notice_s note_data,
    input  wire logic [1:0]               ack_mode,
    output logic                          note_ack,
    output logic [7:0]                    seen_count,
    output valve_alert_pkg::notice_s      last_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] delay_ff;
    logic       pending_ff;
    initial begin
        note_ack = 1'b0;
        seen_count = 8'h00;
        pending_ff = 1'b0;
        delay_ff = 4'h0;
        last_data = '0;
    end
    // Mode 0 never acks, forcing a resend; mode 2 acks late
    always @(posedge clk) begin
        note_ack <= 1'b0;
        if (note_valid) begin
            seen_count <= seen_count + 8'h01;
            last_data  <= note_data;
            pending_ff <= (ack_mode != 2'h0);
            delay_ff   <= (ack_mode == 2'h2) ? 4'h8 : 4'h1;
        end else if (pending_ff) begin
            delay_ff <= delay_ff - 4'h1;
            if (delay_ff == 4'h1) begin
                note_ack   <= 1'b1;
                pending_ff <= 1'b0;
            end
        end
    end
endmodule : valve_host_model

// ===== tb_valve_alert_monitor.sv
// Self-checking bench for the valve alert monitor.
// Assumes the 1 ms tick of the design; longest test spans two ticks.
`include "valve_alert_defines.svh"
module tb_valve_alert_monitor;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  drive_cmd = 8'h32, drive_meas = 8'h32, travel = 8'h32;
    logic        prog_fail = 0, static_fail = 0, main_fail = 0;
    logic        io_fail = 0, sp_update = 0, dflt_restart = 0;
    logic        note_ack, note_valid, shutdown, irq;
    logic [1:0]  mode, bresp, rresp;
    logic [1:0]  ack_mode = 2'h1;
    logic [7:0]  seen_count, awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0]  wstrb = 4'hF;
    int          fail_count = 0, checked = 0, cycles = 0;
    valve_alert_pkg::notice_s note_data, last_data, first;
    localparam logic [7:0] sat_cmd [10] = '{5, 95, 5, 95, 5, 5, 95, 95, 10, 90};
    localparam logic [7:0] sat_trv [10] = '{50, 50, 50, 50, 2, 98, 98, 2, 50, 50};
    localparam logic [9:0] sat_open = 10'h2AC;
    localparam logic [9:0] sat_exp  = 10'h00F;

    valve_alert_monitor u_dut (
        .CORE_CLK(clk), .RESET_N(rst_n), .DRIVE_CMD(drive_cmd),
        .DRIVE_MEAS(drive_meas), .TRAVEL(travel), .PROG_MEM_FAIL(prog_fail),
        .STATIC_MEM_FAIL(static_fail), .MAIN_CPU_FAIL(main_fail),
        .IO_CPU_FAIL(io_fail), .SETPOINT_UPDATE(sp_update),
        .DEFAULTS_RESTART(dflt_restart), .NOTE_ACK(note_ack),
        .NOTE_VALID(note_valid), .NOTE_DATA(note_data), .SHUTDOWN(shutdown),
        .ACTUAL_MODE(mode), .IRQ(irq), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready)
    );
    valve_host_model u_host (
        .clk(clk), .note_valid(note_valid), .note_data(note_data),
        .ack_mode(ack_mode), .note_ack(note_ack), .seen_count(seen_count),
        .last_data(last_data)
    );

    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            fail_count++;
            results();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // Bready held from the start so no response can be missed
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
    endtask : wr

    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                break;
            end
        end
        rready <= 1'b0;
    endtask : rd_reg

    task t_reset;
        check(note_valid, 0, "notice idle");
        check(shutdown, 0, "no shutdown");
        check(mode, 2, "auto mode");
        check(irq, 0, "irq idle");
        rd_reg(`REG_ENABLE, rd);
        check(rd, `RST_ENABLE, "enable reset");
        rd_reg(`REG_ACK_TIMEOUT, rd);
        check(rd, `RST_ACK_TIMEOUT, "ack timeout reset");
        rd_reg(8'h3C, rd);
        check(rd, 0, "unmapped read");
    endtask : t_reset

    task t_notice;
        logic [7:0] n;
        n = seen_count;
        wr(`REG_MASK, 0);
        wr(`REG_STATUS, 32'h7);
        wr(`REG_ALERT_KEY, 32'h5A);
        wr(`REG_CATEGORY, 32'h1B);
        check(irq, 0, "irq masked");
        ack_mode <= 2'h2;
        main_fail <= 1'b1;
        sp_update <= 1'b1;
        @(posedge clk);
        main_fail <= 1'b0;
        sp_update <= 1'b0;
        repeat (4) @(posedge clk);
        check(seen_count, n + 8'h01, "notice after brief fault");
        check(last_data.key, 8'h5A, "notice key");
        check(last_data.alerts, 8'h10, "main cpu alert");
        check(last_data.category, 8'h1B, "notice category");
        rd_reg(`REG_STATUS, rd);
        check(rd[0], 1, "alert status");
        wr(`REG_MASK, 1);
        repeat (2) @(posedge clk);
        check(irq, 1, "irq unmasked");
        wr(`REG_STATUS, 1);
        repeat (2) @(posedge clk);
        check(irq, 0, "irq cleared");
        ack_mode <= 2'h1;
    endtask : t_notice

    task t_enable;
        wr(`REG_ENABLE, 32'hFB);
        wr(`REG_CTRL, 1);
        prog_fail <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(`REG_ACTIVE, rd);
        check(rd[2], 0, "disabled alert");
        check(shutdown, 0, "disabled no shutdown");
        prog_fail <= 1'b0;
        wr(`REG_ENABLE, 32'hFF);
    endtask : t_enable

    task t_auto;
        wr(`REG_CTRL, 3);
        main_fail <= 1'b1;
        repeat (4) @(posedge clk);
        check(shutdown, 0, "main cpu no shutdown");
        main_fail <= 1'b0;
        io_fail <= 1'b1;
        repeat (4) @(posedge clk);
        check(shutdown, 1, "io cpu shutdown");
        check(mode, 0, "out of service");
        io_fail <= 1'b0;
        repeat (4) @(posedge clk);
        check(mode, 2, "auto resume");
        check(shutdown, 0, "shutdown ended");
    endtask : t_auto

    task t_manual;
        wr(`REG_CTRL, 1);
        static_fail <= 1'b1;
        repeat (4) @(posedge clk);
        check(shutdown, 1, "static shutdown");
        dflt_restart <= 1'b1;
        @(posedge clk);
        dflt_restart <= 1'b0;
        rd_reg(`REG_ACTIVE, rd);
        check(rd[7], 1, "defaults alert");
        wr(`REG_CTRL, 32'h19);
        repeat (2) @(posedge clk);
        check(mode, 0, "cause persists");
        static_fail <= 1'b0;
        repeat (4) @(posedge clk);
        check(mode, 0, "manual hold");
        wr(`REG_CTRL, 32'h19);
        repeat (3) @(posedge clk);
        check(mode, 1, "manual recovery");
        rd_reg(`REG_ACTIVE, rd);
        check(rd[7], 0, "defaults alert gone");
        prog_fail <= 1'b1;
        repeat (4) @(posedge clk);
        check(mode, 0, "prog mem shutdown");
        wr(`REG_CTRL, 0);
        repeat (3) @(posedge clk);
        check(mode != 2'h0, 1, "disarm releases");
        prog_fail <= 1'b0;
    endtask : t_manual

    task t_sat;
        for (int i = 0; i < 10; i++) begin
            wr(`REG_CTRL, {29'h0, sat_open[i], 2'h0});
            drive_cmd <= sat_cmd[i];
            drive_meas <= sat_cmd[i];
            travel <= sat_trv[i];
            repeat (4) @(posedge clk);
            rd_reg(`REG_ACTIVE, rd);
            check(rd[1], sat_exp[i], "saturation");
        end
        drive_cmd <= 8'h32;
        drive_meas <= 8'h32;
        travel <= 8'h32;
    endtask : t_sat

    // Time of zero keeps the wait to one tick
    task t_mismatch;
        wr(`REG_MISMATCH_TIME, 0);
        wr(`REG_MISMATCH_THR, 5);
        drive_meas <= 8'h37;
        repeat (20010) @(posedge clk);
        rd_reg(`REG_ACTIVE, rd);
        check(rd[0], 0, "error at threshold");
        drive_meas <= 8'h38;
        repeat (20010) @(posedge clk);
        rd_reg(`REG_ACTIVE, rd);
        check(rd[0], 1, "error above threshold");
        drive_meas <= 8'h32;
        repeat (4) @(posedge clk);
        rd_reg(`REG_ACTIVE, rd);
        check(rd[0], 0, "mismatch dropped");
    endtask : t_mismatch

    task t_retry;
        logic [7:0] n;
        n = seen_count;
        wr(`REG_ACK_TIMEOUT, 1);
        ack_mode <= 2'h0;
        main_fail <= 1'b1;
        @(posedge clk);
        main_fail <= 1'b0;
        repeat (4) @(posedge clk);
        check(seen_count, n + 8'h01, "first notice");
        first = last_data;
        ack_mode <= 2'h1;
        for (int i = 0; i < 25000 && seen_count != n + 8'h02; i++)
            @(posedge clk);
        check(seen_count, n + 8'h02, "notice resent");
        check(last_data, first, "same notice");
    endtask : t_retry

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_notice;
        t_enable;
        t_auto;
        t_manual;
        t_sat;
        t_mismatch;
        t_retry;
        results();
    end
endmodule : tb_valve_alert_monitor
